// ### include/branch_pkg.sv
package branch_pkg;
	localparam int PC_W = 21;
	localparam logic [7:0] OPC_NEG = 8'he6;
	localparam logic [7:0] OPC_NOCARRY = 8'he3;
	localparam int OPC_MSB = 15;
	localparam int OPC_LSB = 8;
	localparam int LIT_MSB = 7;
	localparam int LIT_LSB = 0;
	localparam logic [7:0] LIT_RESET = 8'h00;
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q2 = 2'h1;
	localparam logic [1:0] Q3 = 2'h2;
	localparam logic [1:0] Q4 = 2'h3;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	typedef enum logic [2:0]
	{
		ST_EXEC = 3'h1,
		ST_TAKEN = 3'h2,
		ST_NOP = 3'h4
	} bstate_t;
endpackage

// ### include/phase_if.sv
`timescale 1ns/10ps
interface phase_if;
	logic [1:0] phase;
	logic q4;
	logic cycleStart;
	modport gen (output phase, output q4, output cycleStart);
	modport use_ (input phase, input q4, input cycleStart);
endinterface

// ### hdl/quarter_phase_gen.sv
`timescale 1ns/10ps
module quarter_phase_gen
(
	input wire logic clk_sys,
	input wire logic srst,
	phase_if.gen ph
);
	logic [1:0] phase_q;
	logic [1:0] phase_d;
	always_comb
	begin
		phase_d = phase_q + 2'h1;
	end
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			phase_q <= branch_pkg::Q1;
		else
			phase_q <= phase_d;
	end
	assign ph.phase = phase_q;
	assign ph.q4 = (phase_q == branch_pkg::Q4);
	assign ph.cycleStart = (phase_q == branch_pkg::Q1);
endmodule

// ### hdl/conditional_branch_unit.sv
`timescale 1ns/10ps
module conditional_branch_unit
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire logic flagNegative,
	input wire logic flagCarry,
	input wire logic [branch_pkg::PC_W-1:0] instrAddr,
	output logic [branch_pkg::PC_W-1:0] pc,
	output logic pcLoad,
	output logic busy,
	output logic nopCycle,
	output logic branchTaken,
	output logic [1:0] phase
);
	phase_if ph();
	quarter_phase_gen u_phase
	(
		.clk_sys(clk_sys),
		.srst(srst),
		.ph(ph)
	);

	function automatic logic [branch_pkg::PC_W-1:0] target(
		input logic [branch_pkg::PC_W-1:0] base,
		input logic [7:0] lit);
		logic [branch_pkg::PC_W-1:0] off;
		off = {{(branch_pkg::PC_W-branch_pkg::LIT_MSB-2){lit[branch_pkg::LIT_MSB]}}, lit, 1'h0};
		target = base + branch_pkg::PC_STEP + off;
	endfunction

	branch_pkg::bstate_t state_q;
	branch_pkg::bstate_t state_d;
	logic [branch_pkg::PC_W-1:0] pc_q;
	logic [branch_pkg::PC_W-1:0] pc_d;
	logic [branch_pkg::PC_W-1:0] base_q;
	logic [branch_pkg::PC_W-1:0] base_d;
	logic [7:0] lit_q;
	logic [7:0] lit_d;
	logic cond_q;
	logic cond_d;
	logic load_q;
	logic load_d;
	logic kindNeg_q;
	logic kindNeg_d;
	logic isNeg;
	logic isNoCarry;
	logic [7:0] opcode;
	logic litSign;
	logic [branch_pkg::PC_W-1:0] litWide;
	logic [branch_pkg::PC_W-1:0] expTarget;

	assign opcode = instrWord[branch_pkg::OPC_MSB:branch_pkg::OPC_LSB];
	assign isNeg = opcode == branch_pkg::OPC_NEG;
	assign isNoCarry = opcode == branch_pkg::OPC_NOCARRY;

	always_comb
	begin
		state_d = state_q;
		pc_d = pc_q;
		base_d = base_q;
		lit_d = lit_q;
		cond_d = cond_q;
		kindNeg_d = kindNeg_q;
		load_d = 1'h0;
		case (state_q)
			branch_pkg::ST_EXEC:
			begin
				// decode at Q1, literal read at Q2, condition at Q3
				if (ph.cycleStart && instrValid && (isNeg || isNoCarry))
				begin
					state_d = branch_pkg::ST_TAKEN;
					base_d = instrAddr;
					kindNeg_d = isNeg;
				end
			end
			branch_pkg::ST_TAKEN:
			begin
				if (ph.phase == branch_pkg::Q2)
					lit_d = instrWord[branch_pkg::LIT_MSB:branch_pkg::LIT_LSB];
				// kind latched at decode, so a word that moves mid-cycle cannot swap the flag
				if (ph.phase == branch_pkg::Q3)
					cond_d = kindNeg_q ? flagNegative : !flagCarry;
				if (ph.q4)
				begin
					if (cond_q)
					begin
						pc_d = target(base_q, lit_q);
						load_d = 1'h1;
						state_d = branch_pkg::ST_NOP;
					end
					else
					begin
						pc_d = base_q + branch_pkg::PC_STEP;
						state_d = branch_pkg::ST_EXEC;
					end
				end
			end
			branch_pkg::ST_NOP:
			begin
				// flushed fetch: whole cycle does nothing
				if (ph.q4)
					state_d = branch_pkg::ST_EXEC;
			end
			default:
				state_d = branch_pkg::ST_EXEC;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_q <= branch_pkg::ST_EXEC;
			pc_q <= branch_pkg::PC_RESET;
			base_q <= branch_pkg::PC_RESET;
			lit_q <= branch_pkg::LIT_RESET;
			cond_q <= 1'h0;
			kindNeg_q <= 1'h0;
			load_q <= 1'h0;
		end
		else
		begin
			state_q <= state_d;
			pc_q <= pc_d;
			base_q <= base_d;
			lit_q <= lit_d;
			cond_q <= cond_d;
			kindNeg_q <= kindNeg_d;
			load_q <= load_d;
		end
	end

	assign pc = pc_q;
	assign pcLoad = load_q;
	assign busy = state_q != branch_pkg::ST_EXEC;
	assign nopCycle = state_q == branch_pkg::ST_NOP;
	assign branchTaken = load_q;
	assign phase = ph.phase;

	property p_load_q4;
		@(posedge clk_sys) disable iff (srst)
		load_d |-> ph.q4 && state_q == branch_pkg::ST_TAKEN;
	endproperty
	a_load_q4: assert property (p_load_q4) else $error("pc load outside q4");

	property p_nop_len;
		@(posedge clk_sys) disable iff (srst)
		$rose(load_q) |-> nopCycle [*4] ##1 !nopCycle;
	endproperty
	a_nop_len: assert property (p_nop_len) else $error("nop cycle not four phases");

	// checker target built apart from target(): offset added twice, not shifted
	assign litSign = lit_q[branch_pkg::LIT_MSB];
	assign litWide = {{(branch_pkg::PC_W-branch_pkg::LIT_MSB-1){litSign}}, lit_q};
	assign expTarget = base_q + branch_pkg::PC_STEP + litWide + litWide;

	property p_target;
		@(posedge clk_sys) disable iff (srst)
		load_q |-> pc_q == expTarget;
	endproperty
	a_target: assert property (p_target) else $error("wrong branch target");

	property p_untaken;
		@(posedge clk_sys) disable iff (srst)
		(state_q == branch_pkg::ST_TAKEN && ph.q4 && !cond_q) |=>
			pc_q == $past(base_q) + branch_pkg::PC_STEP && !busy;
	endproperty
	a_untaken: assert property (p_untaken) else $error("untaken not sequential");

	property p_neg;
		@(posedge clk_sys) disable iff (srst)
		(state_q == branch_pkg::ST_TAKEN && ph.phase == branch_pkg::Q3 && kindNeg_q)
			|=> cond_q == $past(flagNegative);
	endproperty
	a_neg: assert property (p_neg) else $error("negative condition wrong");

	property p_carry;
		@(posedge clk_sys) disable iff (srst)
		(state_q == branch_pkg::ST_TAKEN && ph.phase == branch_pkg::Q3 && !kindNeg_q)
			|=> cond_q == !$past(flagCarry);
	endproperty
	a_carry: assert property (p_carry) else $error("carry condition wrong");

	// pc only moves on the q4 edge of a branch cycle
	property p_pc_hold;
		@(posedge clk_sys) disable iff (srst)
		!(state_q == branch_pkg::ST_TAKEN && ph.q4) |=> pc_q == $past(pc_q);
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc moved outside q4");

	property p_load_pulse;
		@(posedge clk_sys) disable iff (srst)
		load_q |=> !load_q;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("pc load held too long");

	property p_busy_len;
		@(posedge clk_sys) disable iff (srst)
		$rose(busy) |-> busy [*3] ##1 (!busy || nopCycle);
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("branch cycle not four phases");

	property p_load_cond;
		@(posedge clk_sys) disable iff (srst)
		load_q |-> $past(cond_q) && $past(ph.q4);
	endproperty
	a_load_cond: assert property (p_load_cond) else $error("pc loaded without condition");

	property p_q4_wrap;
		@(posedge clk_sys) disable iff (srst)
		ph.q4 |=> ph.cycleStart;
	endproperty
	a_q4_wrap: assert property (p_q4_wrap) else $error("phase did not wrap after q4");

	property p_base_held;
		@(posedge clk_sys) disable iff (srst)
		busy |=> base_q == $past(base_q);
	endproperty
	a_base_held: assert property (p_base_held) else $error("request taken while busy");
endmodule

// ### test/conditional_branch_unit_bench.sv
`timescale 1ns/10ps
module conditional_branch_unit_bench;
	logic clk_sys, srst, instrValid, flagNegative, flagCarry;
	logic pcLoad, busy, nopCycle, branchTaken;
	logic [15:0] instrWord;
	logic [branch_pkg::PC_W-1:0] instrAddr, pc, expPc;
	logic [7:0] rOp, rLit;
	logic rN, rC;
	logic [1:0] phase;
	int n_errors, total_checks, seed, i;
	conditional_branch_unit i_dut (.clk_sys(clk_sys), .srst(srst), .instrValid(instrValid),
		.instrWord(instrWord), .flagNegative(flagNegative), .flagCarry(flagCarry),
		.instrAddr(instrAddr), .pc(pc), .pcLoad(pcLoad), .busy(busy), .nopCycle(nopCycle),
		.branchTaken(branchTaken), .phase(phase));
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic tk();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chkBit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	function automatic logic taken(input logic [7:0] op, input logic n, input logic c);
		if (op == branch_pkg::OPC_NEG)
			return n;
		else if (op == branch_pkg::OPC_NOCARRY)
			return !c;
		else
			return 1'h0;
	endfunction
	function automatic logic [20:0] nextPc(input logic [20:0] cur, input logic [20:0] addr,
		input logic [7:0] op, input logic [7:0] lit, input logic n, input logic c);
		logic [20:0] r;
		if (op != branch_pkg::OPC_NEG && op != branch_pkg::OPC_NOCARRY)
			r = cur;
		else
		begin
			r = addr + branch_pkg::PC_STEP;
			if (taken(op, n, c))
				r = r + {{12{lit[7]}}, lit, 1'h0};
		end
		return r;
	endfunction
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic run(input logic [7:0] op, input logic [7:0] lit, input logic n, input logic c);
		logic t;
		logic [20:0] e;
		int k;
		k = 0;
		while (phase !== branch_pkg::Q1 && k < 8)
		begin
			tk();
			k++;
		end
		if (k == 8)
		begin
			n_errors++;
			conclude();
		end
		instrAddr = 21'($random(seed)) & 21'h1ffffe;
		instrWord = {op, lit};
		flagNegative = n;
		flagCarry = c;
		instrValid = 1'h1;
		t = taken(op, n, c);
		e = nextPc(expPc, instrAddr, op, lit, n, c);
		repeat (3) tk();
		// flags flipped after the q3 sample must not reach the outcome
		instrValid = 1'h0;
		flagNegative = !n;
		flagCarry = !c;
		tk();
		chk("pc", e, pc);
		chkBit("pcLoad", t, pcLoad);
		chkBit("branchTaken", t, branchTaken);
		chkBit("nopCycle", t, nopCycle);
		chkBit("busy", t, busy);
		chk("phase", 21'(branch_pkg::Q1), 21'(phase));
		// a second branch offered in the flushed cycle must be ignored
		instrValid = t;
		instrAddr = instrAddr + 21'h000004;
		tk();
		instrValid = 1'h0;
		chkBit("nopMid", t, nopCycle);
		repeat (3) tk();
		chkBit("pcLoadEnd", 1'h0, pcLoad);
		chkBit("busyEnd", 1'h0, busy);
		chk("pcHeld", e, pc);
		expPc = e;
	endtask
	initial
	begin
		seed = 24364;
		srst = 1'h1;
		instrValid = 1'h0;
		instrWord = 16'h0000;
		flagNegative = 1'h0;
		flagCarry = 1'h0;
		instrAddr = 21'h000000;
		expPc = branch_pkg::PC_RESET;
		repeat (2) tk();
		srst = 1'h0;
		chk("resetPc", branch_pkg::PC_RESET, pc);
		chkBit("resetBusy", 1'h0, busy);
		run(branch_pkg::OPC_NEG, 8'h80, 1'h1, 1'h0);
		run(branch_pkg::OPC_NEG, 8'h7f, 1'h0, 1'h1);
		run(branch_pkg::OPC_NEG, 8'h00, 1'h1, 1'h1);
		run(branch_pkg::OPC_NOCARRY, 8'h7f, 1'h1, 1'h0);
		run(branch_pkg::OPC_NOCARRY, 8'hff, 1'h0, 1'h1);
		$display("corner test done");
		for (i = 0; i < 40; i++)
		begin
			rOp = i[0] ? branch_pkg::OPC_NEG : branch_pkg::OPC_NOCARRY;
			rLit = 8'($random(seed));
			rN = 1'($random(seed));
			rC = 1'($random(seed));
			run(rOp, rLit, rN, rC);
		end
		$display("random test done");
		// reset in mid-run must bring pc back to its reset value
		srst = 1'h1;
		repeat (2) tk();
		srst = 1'h0;
		expPc = branch_pkg::PC_RESET;
		chk("midResetPc", branch_pkg::PC_RESET, pc);
		chkBit("midResetBusy", 1'h0, busy);
		$display("reset test done");
		run(8'he7, 8'h05, 1'h0, 1'h0);
		$display("other opcode test done");
		conclude();
	end
endmodule
